// ==== i2c_cond_map.svh ====
`ifndef I2C_COND_MAP_SVH
`define I2C_COND_MAP_SVH

// ----------------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------------
`define CLK_PERIOD_NS   8
`define HOLD_SHORT_NS   100
`define HOLD_LONG_NS    300
`define HOLD_SHORT_CYC  ((`HOLD_SHORT_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define HOLD_LONG_CYC   ((`HOLD_LONG_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define HOLD_CNT_W      6

// ----------------------------------------------------------------------------
// Address fields
// ----------------------------------------------------------------------------
`define TEN_HIGH_PREFIX 5'h1E
`define TEN_PREFIX_MSB  7
`define TEN_PREFIX_LSB  3
`define TEN_UPPER_MSB   2
`define TEN_UPPER_LSB   1
`define RW_BIT          0

// ----------------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------------
`define RST_LINE        1'h1
`define RST_FLAG        1'h0

`endif

// ==== i2c_cond_pkg.sv ====
package i2c_cond_pkg;

   typedef enum logic [2:0] {
      ADDR_IDLE,
      ADDR_FIRST,
      ADDR_LOW,
      ADDR_RX,
      ADDR_TX
   } addr_state_t;

   typedef logic [7:0] byte_t;

endpackage : i2c_cond_pkg

// ==== i2c_bus_condition_logic.sv ====
`timescale 1ns/1ps
`include "i2c_cond_map.svh"

module i2c_bus_condition_logic (
   input  wire logic                core_clk_i,
   input  wire logic                rst_n_i,
   input  wire logic                port_enable_bit_i,
   input  wire logic                i2c_mode_i,
   input  wire logic                ten_bit_mode_i,
   input  wire logic                sda_hold_select_i,
   input  wire i2c_cond_pkg::byte_t slave_address_register_i,
   input  wire i2c_cond_pkg::byte_t rx_byte_i,
   input  wire logic                rx_byte_valid_i,
   input  wire logic                sda_bit_req_i,
   input  wire logic                transmitting_i,
   input  wire logic                start_req_i,
   input  wire logic                scl_low_req_i,
   input  wire logic                tx_data_loaded_i,
   input  wire logic                collision_clr_i,
   input  wire logic                sda_i,
   input  wire logic                scl_i,
   output logic                     sda_o,
   output logic                     sda_oe_n_o,
   output logic                     scl_o,
   output logic                     scl_oe_n_o,
   output logic                     bus_active_o,
   output logic                     start_det_o,
   output logic                     stop_det_o,
   output logic                     restart_det_o,
   output logic                     collision_o,
   output logic                     write_req_o,
   output logic                     read_req_o,
   output logic                     prior_match_o,
   output logic                     tx_mode_o,
   output logic                     rx_mode_o,
   output logic                     expect_addr_o,
   output logic                     scl_stretch_o
);
   import i2c_cond_pkg::*;

   // -------------------------------------------------------------------------
   // State
   // -------------------------------------------------------------------------
   typedef struct packed {
      logic                   sda_m;
      logic                   sda_s;
      logic                   sda_p;
      logic                   scl_m;
      logic                   scl_s;
      logic                   scl_p;
      logic                   active;
      logic                   low_seen;
      logic                   start_p;
      logic                   stop_p;
      logic                   restart_p;
      logic                   coll;
      logic                   start_gen;
      logic [`HOLD_CNT_W-1:0] hold_cnt;
      logic                   sda_rel;
      logic                   scl_rel;
      logic                   pin_data;
      addr_state_t            addr_st;
      logic                   prior;
      logic                   write_p;
      logic                   read_p;
      logic                   stretch;
      logic                   tx_m;
      logic                   rx_m;
      logic                   exp_a;
   } state_t;

   // Counts round up, so the hold on the pins is never shorter than asked.
   localparam logic [`HOLD_CNT_W-1:0] HOLD_SHORT = `HOLD_CNT_W'(`HOLD_SHORT_CYC);
   localparam logic [`HOLD_CNT_W-1:0] HOLD_LONG  = `HOLD_CNT_W'(`HOLD_LONG_CYC);

   state_t st;
   state_t next_st;

   logic enabled;
   logic scl_fall;
   logic start_cond;
   logic stop_cond;
   logic hi_match;
   logic rw;

   // -------------------------------------------------------------------------
   // Next state
   // -------------------------------------------------------------------------
   always_comb begin
      next_st = st;
      next_st.start_p   = 1'h0;
      next_st.stop_p    = 1'h0;
      next_st.restart_p = 1'h0;
      next_st.write_p   = 1'h0;
      next_st.read_p    = 1'h0;

      enabled = port_enable_bit_i & i2c_mode_i;

      // ----------------------------------------------------------------------
      // Synchronisers
      // ----------------------------------------------------------------------
      // Only the second stage feeds logic; the first stage may be metastable.
      // The third stage is kept only to compare against for edge detection.
      next_st.sda_m = sda_i;
      next_st.sda_s = st.sda_m;
      next_st.sda_p = st.sda_s;
      next_st.scl_m = scl_i;
      next_st.scl_s = st.scl_m;
      next_st.scl_p = st.scl_s;

      scl_fall   = st.scl_p & ~st.scl_s;
      start_cond = st.scl_s & st.scl_p & st.sda_p & ~st.sda_s;
      stop_cond  = st.scl_s & st.scl_p & ~st.sda_p & st.sda_s;

      rw       = rx_byte_i[`RW_BIT];
      hi_match = (rx_byte_i[`TEN_PREFIX_MSB:`TEN_PREFIX_LSB] == `TEN_HIGH_PREFIX) &&
                 (rx_byte_i[`TEN_UPPER_MSB:`TEN_UPPER_LSB] ==
                  slave_address_register_i[`TEN_UPPER_MSB:`TEN_UPPER_LSB]);

      // ----------------------------------------------------------------------
      // Bus state and conditions
      // ----------------------------------------------------------------------
      // Any synchronised SCL low arms the next Stop or Restart.
      if (!st.scl_s) begin
         next_st.low_seen = 1'h1;
      end
      if (start_cond) begin
         next_st.active   = 1'h1;
         next_st.low_seen = 1'h0;
         if (st.active && st.low_seen) begin
            next_st.restart_p = 1'h1;
         end else begin
            next_st.start_p = 1'h1;
         end
      end else if (stop_cond && st.low_seen) begin
         // A Stop without an SCL low since the Start is not a Stop at all.
         next_st.stop_p   = 1'h1;
         next_st.active   = 1'h0;
         next_st.low_seen = 1'h0;
      end else if (!st.active && !st.sda_s && !st.scl_s) begin
         // Both lines low with no Start seen means someone already owns the bus.
         next_st.active = 1'h1;
      end

      // ----------------------------------------------------------------------
      // Collision
      // ----------------------------------------------------------------------
      // Set beats clear, so a collision that meets a clear is never lost.
      if (collision_clr_i) begin
         next_st.coll = 1'h0;
      end
      if (enabled && transmitting_i && st.sda_rel && !st.sda_s && st.scl_s) begin
         next_st.coll = 1'h1;
      end

      // ----------------------------------------------------------------------
      // Start generation
      // ----------------------------------------------------------------------
      // A request on a busy bus is ignored; software waits for a Stop first.
      if (enabled && start_req_i && !st.active) begin
         if (!st.sda_s) begin
            next_st.coll = 1'h1;
         end else begin
            next_st.start_gen = 1'h1;
         end
      end
      if (start_cond || !enabled) begin
         next_st.start_gen = 1'h0;
      end

      // ----------------------------------------------------------------------
      // SDA hold
      // ----------------------------------------------------------------------
      // The count starts at the synchronised fall, so the hold on the pins is three cycles longer.
      if (scl_fall) begin
         next_st.hold_cnt = sda_hold_select_i ? HOLD_LONG : HOLD_SHORT;
      end else if (st.hold_cnt != '0) begin
         next_st.hold_cnt = st.hold_cnt - `HOLD_CNT_W'(1);
      end

      if (!enabled) begin
         next_st.sda_rel = 1'h1;
      end else if (next_st.start_gen) begin
         next_st.sda_rel = 1'h0;
      end else if (!scl_fall && st.hold_cnt == '0) begin
         next_st.sda_rel = sda_bit_req_i;
      end

      // ----------------------------------------------------------------------
      // Address matching and slave direction
      // ----------------------------------------------------------------------
      if (start_cond) begin
         next_st.addr_st = ADDR_FIRST;
         next_st.stretch = 1'h0;
      end else if (stop_cond && st.low_seen) begin
         next_st.addr_st = ADDR_IDLE;
         next_st.prior   = 1'h0;
         next_st.stretch = 1'h0;
      end else if (rx_byte_valid_i) begin
         unique case (st.addr_st)
            ADDR_FIRST: begin
               if (!ten_bit_mode_i) begin
                  if (rx_byte_i[7:1] == slave_address_register_i[7:1]) begin
                     if (rw) begin
                        next_st.addr_st = ADDR_TX;
                        next_st.read_p  = 1'h1;
                        next_st.stretch = 1'h1;
                     end else begin
                        next_st.addr_st = ADDR_RX;
                        next_st.write_p = 1'h1;
                     end
                  end else begin
                     next_st.addr_st = ADDR_IDLE;
                  end
               end else if (!hi_match) begin
                  next_st.addr_st = ADDR_IDLE;
                  next_st.prior   = 1'h0;
               end else if (!rw) begin
                  next_st.addr_st = ADDR_LOW;
                  next_st.prior   = 1'h0;
               end else if (st.prior) begin
                  // A read is honoured only after a full write match earlier.
                  next_st.addr_st = ADDR_TX;
                  next_st.read_p  = 1'h1;
                  next_st.stretch = 1'h1;
               end else begin
                  next_st.addr_st = ADDR_IDLE;
               end
            end
            ADDR_LOW: begin
               // The low byte is compared in all eight bits.
               if (rx_byte_i == slave_address_register_i) begin
                  next_st.addr_st = ADDR_RX;
                  next_st.write_p = 1'h1;
                  next_st.prior   = 1'h1;
               end else begin
                  next_st.addr_st = ADDR_IDLE;
               end
            end
            // Bytes that arrive outside an address phase are data and are ignored here.
            ADDR_IDLE,
            ADDR_RX,
            ADDR_TX: begin
               next_st.addr_st = st.addr_st;
            end
            default: begin
               // An illegal code falls back to idle rather than locking up.
               next_st.addr_st = ADDR_IDLE;
            end
         endcase
      end

      // A load that meets a new read request leaves the stretch set; the request wins.
      if (tx_data_loaded_i && !next_st.read_p) begin
         next_st.stretch = 1'h0;
      end
      if (!enabled) begin
         next_st.addr_st = ADDR_IDLE;
         next_st.prior   = 1'h0;
         next_st.stretch = 1'h0;
      end

      // ----------------------------------------------------------------------
      // Pin drive
      // ----------------------------------------------------------------------
      // Holding SCL low stalls every agent on the bus.
      next_st.scl_rel  = ~(enabled & (next_st.stretch | scl_low_req_i));
      next_st.pin_data = 1'h0;

      // ----------------------------------------------------------------------
      // Registered mode outputs
      // ----------------------------------------------------------------------
      next_st.tx_m  = (next_st.addr_st == ADDR_TX);
      next_st.rx_m  = (next_st.addr_st == ADDR_RX);
      next_st.exp_a = (next_st.addr_st == ADDR_FIRST) | (next_st.addr_st == ADDR_LOW);
   end

   // -------------------------------------------------------------------------
   // Registers
   // -------------------------------------------------------------------------
   always_ff @(posedge core_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         st           <= '0;
         // Line stages reset to the idle level, so no false edge follows reset.
         st.sda_m     <= `RST_LINE;
         st.sda_s     <= `RST_LINE;
         st.sda_p     <= `RST_LINE;
         st.scl_m     <= `RST_LINE;
         st.scl_s     <= `RST_LINE;
         st.scl_p     <= `RST_LINE;
         st.sda_rel   <= `RST_LINE;
         st.scl_rel   <= `RST_LINE;
         st.coll      <= `RST_FLAG;
         st.addr_st   <= ADDR_IDLE;
      end else begin
         st <= next_st;
      end
   end

   // -------------------------------------------------------------------------
   // Outputs
   // -------------------------------------------------------------------------
   // Pins are only ever pulled low or released; the data bit stays zero.
   assign sda_o         = st.pin_data;
   assign scl_o         = st.pin_data;
   assign sda_oe_n_o    = st.sda_rel;
   assign scl_oe_n_o    = st.scl_rel;
   assign bus_active_o  = st.active;
   assign start_det_o   = st.start_p;
   assign stop_det_o    = st.stop_p;
   assign restart_det_o = st.restart_p;
   assign collision_o   = st.coll;
   assign write_req_o   = st.write_p;
   assign read_req_o    = st.read_p;
   assign prior_match_o = st.prior;
   // Mode outputs are registered too, so nothing downstream sees a decode glitch.
   assign tx_mode_o     = st.tx_m;
   assign rx_mode_o     = st.rx_m;
   assign expect_addr_o = st.exp_a;
   assign scl_stretch_o = st.stretch;

endmodule : i2c_bus_condition_logic

// ==== i2c_bus_condition_chk.sv ====
`timescale 1ns/1ps
module i2c_bus_condition_chk (
   input wire logic                core_clk_i,
   input wire logic                rst_n_i,
   input wire logic                port_enable_bit_i,
   input wire logic                i2c_mode_i,
   input wire logic                ten_bit_mode_i,
   input wire logic                sda_hold_select_i,
   input wire i2c_cond_pkg::byte_t slave_address_register_i,
   input wire i2c_cond_pkg::byte_t rx_byte_i,
   input wire logic                rx_byte_valid_i,
   input wire logic                transmitting_i,
   input wire logic                start_req_i,
   input wire logic                collision_clr_i,
   input wire logic                sda_i,
   input wire logic                scl_i,
   input wire logic                sda_o,
   input wire logic                sda_oe_n_o,
   input wire logic                scl_o,
   input wire logic                scl_oe_n_o,
   input wire logic                bus_active_o,
   input wire logic                start_det_o,
   input wire logic                stop_det_o,
   input wire logic                restart_det_o,
   input wire logic                collision_o,
   input wire logic                write_req_o,
   input wire logic                read_req_o,
   input wire logic                prior_match_o,
   input wire logic                scl_stretch_o
);
   import i2c_cond_pkg::*;
   default clocking @(posedge core_clk_i); endclocking
   default disable iff (!rst_n_i);
   // ----------------------------------------------------------------------
   // Bus conditions
   // ----------------------------------------------------------------------
   sequence scl_fall_s;
      scl_i ##1 !scl_i;
   endsequence
   // The freeze is checked from the fourth edge on, because a request made just before the fall may land late.
   chk_hold_long: assert property ((scl_fall_s ##0 (sda_hold_select_i && port_enable_bit_i && i2c_mode_i)) |->
      ##4 $stable(sda_oe_n_o)[*8]) else $error("sda drive changed inside hold time");
   chk_data_zero: assert property (!sda_o && !scl_o) else $error("pin data not zero");
   chk_off_release: assert property (!$past(port_enable_bit_i && i2c_mode_i) && !(port_enable_bit_i && i2c_mode_i)
      |-> sda_oe_n_o && scl_oe_n_o) else $error("pins driven while disabled");
   chk_start_cause: assert property (start_det_o |-> bus_active_o && !$past(sda_i, 2) && $past(scl_i, 2))
      else $error("start without sda fall under high scl");
   chk_stop_idle: assert property (stop_det_o |-> ##1 (!bus_active_o && !prior_match_o))
      else $error("bus or prior match kept after stop");
   chk_restart_cause: assert property (restart_det_o |-> bus_active_o && !$past(sda_i, 2))
      else $error("restart outside active bus");
   chk_write_cause: assert property (write_req_o |-> $past(rx_byte_valid_i) &&
      ($past(ten_bit_mode_i) ? $past(rx_byte_i) == $past(slave_address_register_i) : !$past(rx_byte_i[0])))
      else $error("write request without matching write byte");
   chk_read_stretch: assert property (read_req_o |-> scl_stretch_o && !scl_oe_n_o)
      else $error("read request without clock stretch");
   chk_prior_set: assert property (write_req_o && ten_bit_mode_i |-> prior_match_o)
      else $error("prior match missing after full match");
   chk_coll_sticky: assert property (collision_o && !collision_clr_i |=> collision_o)
      else $error("collision flag dropped");
   chk_coll_cause: assert property ($rose(collision_o) |-> $past(transmitting_i) || $past(start_req_i))
      else $error("collision without own drive");
endmodule : i2c_bus_condition_chk

bind i2c_bus_condition_logic i2c_bus_condition_chk chk (.*);

// ==== i2c_far_master.sv ====
`timescale 1ns/1ps
module i2c_far_master (
   input  wire logic core_clk_i,
   input  wire logic sda_oe_n_i,
   input  wire logic scl_oe_n_i,
   output logic      sda_line_o,
   output logic      scl_line_o
);
   logic sda_rel = 1'h1;
   logic scl_rel = 1'h1;
   int   stall_cnt = 0;
   // Both lines are pulled up, so a released line reads high.
   assign sda_line_o = sda_rel & sda_oe_n_i;
   assign scl_line_o = scl_rel & scl_oe_n_i;
   // Ten system cycles make half of the 160 ns bench SCL period.
   task automatic wait_q(input int n = 10);
      repeat (n) @(negedge core_clk_i);
   endtask : wait_q
   task automatic scl_up;
      int k;
      k = 0;
      scl_rel = 1'h1;
      while (!scl_line_o && k < 200) begin
         wait_q(1);
         k++;
      end
      if (k >= 200) begin
         stall_cnt++;
      end
      wait_q();
   endtask : scl_up
   task automatic start_cond;
      wait_q();
      sda_rel = 1'h0;
      wait_q();
      scl_rel = 1'h0;
      wait_q();
   endtask : start_cond
   task automatic restart_cond;
      sda_rel = 1'h1;
      wait_q();
      scl_up();
      start_cond();
   endtask : restart_cond
   task automatic stop_cond;
      scl_rel = 1'h0;
      wait_q();
      sda_rel = 1'h0;
      wait_q();
      scl_up();
      sda_rel = 1'h1;
      wait_q();
   endtask : stop_cond
endmodule : i2c_far_master

// ==== i2c_bus_condition_logic_bench.sv ====
`timescale 1ns/1ps
`include "i2c_cond_map.svh"
module i2c_bus_condition_logic_bench;
   import i2c_cond_pkg::*;
   logic  core_clk_i = 0, rst_n_i = 0, port_enable_bit_i = 1, i2c_mode_i = 1, ten_bit_mode_i = 0;
   logic  sda_hold_select_i = 0, rx_byte_valid_i = 0, sda_bit_req_i = 1, transmitting_i = 0, start_req_i = 0;
   logic  scl_low_req_i = 0, tx_data_loaded_i = 0, collision_clr_i = 0, sda_i, scl_i, sda_o, sda_oe_n_o;
   logic  scl_o, scl_oe_n_o, bus_active_o, start_det_o, stop_det_o, restart_det_o, collision_o, write_req_o;
   logic  read_req_o, prior_match_o, tx_mode_o, rx_mode_o, expect_addr_o, scl_stretch_o;
   byte_t slave_address_register_i = 8'h00, rx_byte_i = 8'h00, a, r;
   int    error_cnt = 0, checks = 0, n_st = 0, n_sp = 0, n_rs = 0, n_wr = 0, n_rd = 0, w0, r0, n, h;
   i2c_bus_condition_logic DUT (.*);
   i2c_far_master far (.core_clk_i(core_clk_i), .sda_oe_n_i(sda_oe_n_o), .scl_oe_n_i(scl_oe_n_o),
                       .sda_line_o(sda_i), .scl_line_o(scl_i));
   initial forever #4 core_clk_i = ~core_clk_i;
   always @(posedge core_clk_i) begin
      n_st += start_det_o; n_sp += stop_det_o; n_rs += restart_det_o; n_wr += write_req_o; n_rd += read_req_o;
   end
   task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
      checks++;
      if (seen !== exp) begin
         error_cnt++;
         $display("mismatch at %0t: got %h expected %h", $time, seen, exp);
      end
   endtask : chk
   task automatic summarize;
      $display("checks %0d mismatches %0d", checks, error_cnt);
      if (error_cnt == 0 && checks > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask : summarize
   task automatic tick(input int k);
      repeat (k) @(negedge core_clk_i);
   endtask : tick
   task automatic send(input byte_t b);
      rx_byte_i = b; rx_byte_valid_i = 1; tick(1); rx_byte_valid_i = 0; tick(2);
   endtask : send
   task automatic pulse_loaded;
      tx_data_loaded_i = 1; tick(1); tx_data_loaded_i = 0; tick(2);
   endtask : pulse_loaded
   initial begin
      repeat (50000) @(posedge core_clk_i);
      error_cnt++;
      summarize();
   end
   initial begin
      void'($urandom(35));
      tick(3); rst_n_i = 1; tick(6);
      chk(sda_o, 0); chk(scl_o, 0);
      chk(sda_oe_n_o, 1); chk(scl_oe_n_o, 1); chk(bus_active_o, 0);
      far.sda_rel = 0; tick(10); far.sda_rel = 1; tick(10);
      chk(n_st, 1); chk(n_sp, 0); chk(bus_active_o, 1);
      far.stop_cond(); tick(6);
      chk(n_sp, 1); chk(bus_active_o, 0);
      $display("conditions test done");
      for (int i = 0; i < 8; i++) begin
         a = $urandom; slave_address_register_i = a; r = i[0] ? a ^ {7'h0, i[1]} : byte_t'($urandom);
         w0 = n_wr; r0 = n_rd;
         far.start_cond(); send(r);
         chk(n_wr - w0, a[7:1] == r[7:1] && !r[0]); chk(n_rd - r0, a[7:1] == r[7:1] && r[0]);
         chk(rx_mode_o, a[7:1] == r[7:1] && !r[0]); chk(scl_stretch_o, a[7:1] == r[7:1] && r[0]);
         pulse_loaded(); chk(scl_oe_n_o, 1); far.stop_cond();
      end
      $display("seven bit test done");
      ten_bit_mode_i = 1; a = $urandom; slave_address_register_i = a; w0 = n_wr; r0 = n_rd;
      // Full write match, then restart with the read bit, as a master must do.
      far.start_cond(); send({5'h1E, a[2:1], 1'b0}); send(a);
      chk(n_wr - w0, 1); chk(prior_match_o, 1);
      far.restart_cond(); tick(6); chk(n_rs, 1); chk(expect_addr_o, 1);
      send({5'h1E, a[2:1], 1'b1}); chk(n_rd - r0, 1); chk(scl_stretch_o, 1); chk(tx_mode_o, 1);
      pulse_loaded(); far.stop_cond(); tick(6); chk(prior_match_o, 0);
      $display("ten bit test done");
      far.start_cond(); transmitting_i = 1; far.scl_rel = 1; tick(8);
      chk(collision_o, 1); transmitting_i = 0;
      collision_clr_i = 1; tick(1); collision_clr_i = 0; tick(2); chk(collision_o, 0);
      far.stop_cond();
      for (int s = 0; s < 2; s++) begin
         sda_hold_select_i = s[0]; h = s[0] ? `HOLD_LONG_CYC : `HOLD_SHORT_CYC;
         far.start_cond(); far.scl_rel = 1; tick(10);
         // The shifter moves its bit only once the design has seen the fall.
         far.scl_rel = 0; tick(3); sda_bit_req_i = 0; n = 0;
         while (sda_oe_n_o !== 0 && n < 100) begin
            tick(1); n++;
         end
         chk(n >= h && n <= h + 6, 1);
         sda_bit_req_i = 1; tick(50); far.stop_cond();
      end
      $display("hold and collision test done");
      // Dropping the enable in mid-read must release both pins at once.
      ten_bit_mode_i = 0; far.start_cond(); send({a[7:1], 1'b1});
      chk(scl_oe_n_o, 0);
      port_enable_bit_i = 0; tick(2);
      chk(scl_oe_n_o, 1); chk(sda_oe_n_o, 1); chk(tx_mode_o, 0);
      port_enable_bit_i = 1; far.stop_cond();
      // Own Start on an idle bus: SDA is pulled until the Start shows on the lines.
      start_req_i = 1; tick(1); start_req_i = 0;
      chk(sda_oe_n_o, 0);
      w0 = n_st; tick(8);
      chk(n_st - w0, 1); chk(bus_active_o, 1);
      far.stop_cond();
      // Another agent pulls SDA two cycles before our Start request is taken.
      far.sda_rel = 0; tick(2); start_req_i = 1; tick(1); start_req_i = 0; tick(2);
      chk(collision_o, 1);
      collision_clr_i = 1; tick(1); collision_clr_i = 0; tick(2); chk(collision_o, 0);
      far.stop_cond();
      scl_low_req_i = 1; tick(1); chk(scl_oe_n_o, 0);
      scl_low_req_i = 0; tick(1); chk(scl_oe_n_o, 1);
      chk(far.stall_cnt, 0);
      $display("enable and start request test done");
      summarize();
   end
endmodule : i2c_bus_condition_logic_bench
